// file: rtl/aswo_consts.svh
`ifndef ASWO_CONSTS_SVH
`define ASWO_CONSTS_SVH
`define ASWO_CLK_HZ          10000000
`define ASWO_SLEEP_MIN_US    200
`define ASWO_SLEEP_MAX_US    2000
`define ASWO_WAKE_LOW_US     10
`define ASWO_SLEEP_CYC       ((`ASWO_SLEEP_MIN_US * (`ASWO_CLK_HZ / 1000000)))
`define ASWO_WAKE_CYC        ((`ASWO_WAKE_LOW_US * (`ASWO_CLK_HZ / 1000000)))
`define ASWO_CONV_PERIODS    612
`define ASWO_UNSETTLED_CNT   3
`define ASWO_WORD_W          24
`define ASWO_RESULT_RST      24'h00_0000
`endif

// file: rtl/aswo_pkg.sv
package aswo_pkg;
	typedef enum logic [1:0] {
		ASWO_NORMAL,
		ASWO_SLEEP,
		ASWO_WAKING
	} aswo_mode_t;

	typedef struct packed {
		logic [23:0] data;
		logic        unsettled;
	} aswo_result_t;
endpackage

// file: rtl/aswo_sync.sv
`timescale 1ns/10ps
`default_nettype none
module aswo_sync (
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_ff;
	logic sync_ff;
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end
	assign o_sync = sync_ff;
endmodule
`default_nettype wire

// file: rtl/aswo_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "aswo_consts.svh"
module aswo_top
	import aswo_pkg::*;
#(
	parameter int SLEEP_CYC  = `ASWO_SLEEP_CYC,
	parameter bit EXT_CLOCK  = 1'b1
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic        i_sclk,
	input  wire logic        i_cs_n,
	input  wire logic        i_osc_tick,
	input  wire logic [23:0] i_sample,
	output logic             o_serial_data_out,
	output logic             o_serial_data_out_oe,
	output logic             o_sleep,
	output logic             o_filter_rst,
	output logic             o_conv_done,
	output aswo_result_t     o_result
);
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic sclk_s;
	logic cs_s;
	logic osc_s;

	aswo_sync u_sync_sclk (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_async  (i_sclk),
		.o_sync   (sclk_s)
	);

	// Chip select is carried as an active-high select, so that the reset value of the
	// synchroniser keeps the output driver off while reset is applied.
	aswo_sync u_sync_cs (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_async  (~i_cs_n),
		.o_sync   (cs_s)
	);

	aswo_sync u_sync_osc (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_async  (i_osc_tick),
		.o_sync   (osc_s)
	);

	// ****************************************************************
	// Mode control
	// ****************************************************************
	aswo_mode_t   mode_ff,  nxt_mode;
	logic [15:0]  hi_cnt_ff, nxt_hi_cnt;
	logic [15:0]  lo_cnt_ff, nxt_lo_cnt;
	logic         rst_pulse;

	always_comb begin
		nxt_mode   = mode_ff;
		nxt_hi_cnt = hi_cnt_ff;
		nxt_lo_cnt = lo_cnt_ff;
		rst_pulse  = 1'b0;
		if (!sclk_s) begin
			nxt_hi_cnt = 16'h0000;
		end else if (hi_cnt_ff != 16'hffff) begin
			nxt_hi_cnt = hi_cnt_ff + 16'h0001;
		end
		if (sclk_s) begin
			nxt_lo_cnt = 16'h0000;
		end else if (lo_cnt_ff != 16'hffff) begin
			nxt_lo_cnt = lo_cnt_ff + 16'h0001;
		end
		case (mode_ff)
			ASWO_NORMAL: begin
				if (hi_cnt_ff >= 16'(SLEEP_CYC)) begin
					nxt_mode = ASWO_SLEEP;
				end
			end
			ASWO_SLEEP: begin
				if (!sclk_s && lo_cnt_ff >= 16'(`ASWO_WAKE_CYC - 1)) begin
					nxt_mode = ASWO_WAKING;
				end
			end
			ASWO_WAKING: begin
				rst_pulse = 1'b1;
				nxt_mode  = ASWO_NORMAL;
			end
			default: nxt_mode = ASWO_NORMAL;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_ff   <= ASWO_NORMAL;
			hi_cnt_ff <= 16'h0000;
			lo_cnt_ff <= 16'h0000;
		end else begin
			mode_ff   <= nxt_mode;
			hi_cnt_ff <= nxt_hi_cnt;
			lo_cnt_ff <= nxt_lo_cnt;
		end
	end

	// ****************************************************************
	// Edge detection
	// ****************************************************************
	logic sclk_d_ff, nxt_sclk_d;
	logic osc_d_ff,  nxt_osc_d;
	logic sclk_rise;
	logic sclk_fall;
	logic osc_rise;

	always_comb begin
		nxt_sclk_d = sclk_s;
		nxt_osc_d  = osc_s;
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sclk_d_ff <= 1'b0;
			osc_d_ff  <= 1'b0;
		end else begin
			sclk_d_ff <= nxt_sclk_d;
			osc_d_ff  <= nxt_osc_d;
		end
	end

	// The delay flops reset low like the synchronisers, so no false edge follows reset.
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign osc_rise  = osc_s & ~osc_d_ff;

	// ****************************************************************
	// Conversion timing
	// ****************************************************************
	logic         mclk_tick;
	logic         conv_end;
	logic [9:0]   div_ff,    nxt_div;
	logic [1:0]   unset_ff,  nxt_unset;
	logic         done_ff,   nxt_done;
	aswo_result_t res_ff,    nxt_res;

	// Master clock source selects by variant.
	assign mclk_tick = EXT_CLOCK ? sclk_rise : osc_rise;

	always_comb begin
		nxt_div   = div_ff;
		nxt_unset = unset_ff;
		nxt_done  = 1'b0;
		nxt_res   = res_ff;
		conv_end  = 1'b0;
		if (rst_pulse) begin
			nxt_div   = 10'h000;
			nxt_unset = 2'(`ASWO_UNSETTLED_CNT);
			nxt_res   = '0;
		end else if (mode_ff == ASWO_NORMAL && mclk_tick) begin
			if (div_ff == 10'(`ASWO_CONV_PERIODS - 1)) begin
				conv_end          = 1'b1;
				nxt_div           = 10'h000;
				nxt_done          = 1'b1;
				nxt_res.data      = i_sample;
				nxt_res.unsettled = (unset_ff != 2'h0);
				if (unset_ff != 2'h0) begin
					nxt_unset = unset_ff - 2'h1;
				end
			end else begin
				nxt_div = div_ff + 10'h001;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_ff   <= 10'h000;
			unset_ff <= 2'(`ASWO_UNSETTLED_CNT);
			done_ff  <= 1'b0;
			res_ff   <= '0;
		end else begin
			div_ff   <= nxt_div;
			unset_ff <= nxt_unset;
			done_ff  <= nxt_done;
			res_ff   <= nxt_res;
		end
	end

	// ****************************************************************
	// Output shifting
	// ****************************************************************
	logic [23:0] shift_ff, nxt_shift;
	logic        sdo_ff,   nxt_sdo;

	// A new word is loaded at conversion end; in the oscillator variant a falling serial
	// clock in that same cycle is dropped so that the word is never lost.
	always_comb begin
		nxt_shift = shift_ff;
		nxt_sdo   = sdo_ff;
		if (rst_pulse) begin
			nxt_shift = `ASWO_RESULT_RST;
			nxt_sdo   = 1'b0;
		end else if (mode_ff == ASWO_NORMAL) begin
			if (conv_end) begin
				nxt_shift = i_sample;
			end else if (sclk_fall && cs_s) begin
				nxt_sdo   = shift_ff[23];
				nxt_shift = {shift_ff[22:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shift_ff <= `ASWO_RESULT_RST;
			sdo_ff   <= 1'b0;
		end else begin
			shift_ff <= nxt_shift;
			sdo_ff   <= nxt_sdo;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Driver follows chip select in every mode, asleep or not.
	assign o_serial_data_out    = sdo_ff;
	assign o_serial_data_out_oe = cs_s;
	assign o_sleep              = (mode_ff == ASWO_SLEEP);
	assign o_filter_rst         = rst_pulse;
	assign o_conv_done          = done_ff;
	assign o_result             = res_ff;
endmodule
`default_nettype wire

// file: tb/aswo_properties.sv
`timescale 1ns/10ps
`default_nettype none
module aswo_properties
	import aswo_pkg::*;
#(
	parameter int SLEEP_CYC = 2000,
	parameter bit EXT_CLOCK = 1'b1
) (
	input wire logic         i_clk_sys,
	input wire logic         i_reset_n,
	input wire logic         i_sclk,
	input wire logic         i_osc_tick,
	input wire logic         i_cs_n,
	input wire logic         o_serial_data_out_oe,
	input wire logic         o_sleep,
	input wire logic         o_filter_rst,
	input wire logic         o_conv_done,
	input wire aswo_result_t o_result
);
	logic [15:0] hi_ff, lo_ff;
	logic [9:0]  rise_ff;
	logic [1:0]  nconv_ff;
	logic        sclk_ff;
	logic        osc_ff;
	logic        tick;
	assign tick = EXT_CLOCK ? (i_sclk & ~sclk_ff) : (i_osc_tick & ~osc_ff);
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{hi_ff, lo_ff, rise_ff, nconv_ff, sclk_ff, osc_ff} <= '0;
		end else begin
			hi_ff <= i_sclk ? hi_ff + 16'h0001 : 16'h0000;
			lo_ff <= i_sclk ? 16'h0000 : lo_ff + 16'h0001;
			sclk_ff <= i_sclk;
			osc_ff <= i_osc_tick;
			rise_ff <= (o_conv_done || o_filter_rst) ? 10'h000 : rise_ff + {9'h000, tick};
			if (o_filter_rst) nconv_ff <= 2'h0;
			else if (o_conv_done && nconv_ff != 2'h3) nconv_ff <= nconv_ff + 2'h1;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	property p_oe_on; !i_cs_n [*4] |-> o_serial_data_out_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("oe low");
	property p_oe_off; i_cs_n [*4] |-> !o_serial_data_out_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("oe high");
	property p_slp_min; $rose(o_sleep) |-> hi_ff >= SLEEP_CYC; endproperty
	a_slp_min: assert property (p_slp_min) else $error("early sleep");
	property p_slp_max; hi_ff == SLEEP_CYC + 8 |-> o_sleep; endproperty
	a_slp_max: assert property (p_slp_max) else $error("no sleep");
	property p_wake; lo_ff == 16'h006E |-> !o_sleep; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_stay; o_sleep && lo_ff < 16'h005A |=> o_sleep; endproperty
	a_stay: assert property (p_stay) else $error("early wake");
	property p_frst; o_filter_rst |=> !o_filter_rst && !o_sleep; endproperty
	a_frst: assert property (p_frst) else $error("filter reset");
	property p_uns; o_conv_done && nconv_ff != 2'h3 |-> o_result.unsettled; endproperty
	a_uns: assert property (p_uns) else $error("settled early");
	property p_set; o_conv_done && nconv_ff == 2'h3 |-> !o_result.unsettled; endproperty
	a_set: assert property (p_set) else $error("still unsettled");
	property p_rate; o_conv_done |-> rise_ff == 10'h264; endproperty
	a_rate: assert property (p_rate) else $error("rate");
	c_sleep: cover property ($rose(o_sleep));
	c_wake: cover property (o_filter_rst);
	c_ok: cover property (o_conv_done && !o_result.unsettled);
endmodule
bind aswo_top aswo_properties #(.SLEEP_CYC(SLEEP_CYC), .EXT_CLOCK(EXT_CLOCK)) i_aswo_properties (
	.i_clk_sys, .i_reset_n, .i_sclk, .i_osc_tick, .i_cs_n, .o_serial_data_out_oe, .o_sleep,
	.o_filter_rst, .o_conv_done, .o_result);
`default_nettype wire

// file: tb/aswo_host.sv
`timescale 1ns/10ps
`default_nettype none
module aswo_host (
	output logic o_sclk,
	output logic o_cs_n
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
	end
	task automatic pulses(input int n);
		repeat (n) begin
			#400 o_sclk = 1'b1;
			#400 o_sclk = 1'b0;
		end
	endtask
	task automatic hold(input logic s, input logic c, input int ns);
		o_sclk = s;
		o_cs_n = c;
		#(ns);
	endtask
endmodule
`default_nettype wire

// file: tb/aswo_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aswo_top_tb
	import aswo_pkg::*;
;
	localparam int SLP = 20;
	localparam logic [23:0] SMP = 24'h80_0001;
	logic clk, rst_n, sclk, cs_n, oe, sleep, frst, done, osc, serial_data_out, done_o;
	logic sclk_q = 1'b0;
	aswo_result_t res, res_o;
	int n_errors = 0, checked = 0, n_conv = 0, n_uns = 0, n_rst = 0, cyc = 0;
	int n_conv_o = 0, bidx = 24;
	aswo_top #(.SLEEP_CYC(SLP), .EXT_CLOCK(1'b1)) i_aswo_top (.i_clk_sys(clk), .i_reset_n(rst_n),
		.i_sclk(sclk), .i_cs_n(cs_n), .i_osc_tick(1'b0), .i_sample(SMP), .o_serial_data_out(serial_data_out),
		.o_serial_data_out_oe(oe), .o_sleep(sleep), .o_filter_rst(frst), .o_conv_done(done),
		.o_result(res));
	aswo_top #(.SLEEP_CYC(SLP), .EXT_CLOCK(1'b0)) i_aswo_top_osc (.i_clk_sys(clk),
		.i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_osc_tick(osc), .i_sample(SMP),
		.o_serial_data_out(), .o_serial_data_out_oe(), .o_sleep(), .o_filter_rst(),
		.o_conv_done(done_o), .o_result(res_o));
	aswo_host i_aswo_host (.o_sclk(sclk), .o_cs_n(cs_n));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(negedge clk) begin
		cyc++;
		if (sclk === 1'b1 && sclk_q === 1'b0 && cs_n === 1'b0 && bidx < 24) begin
			chk(serial_data_out === SMP[23 - bidx], "shift");
			bidx++;
		end
		sclk_q = sclk;
		if (frst === 1'b1) begin
			n_rst++;
			bidx = 24;
		end
		if (done === 1'b1) begin
			n_conv++;
			bidx = 0;
			if (res.unsettled === 1'b1) n_uns++;
			chk(res.data === SMP, "data");
		end
		if (done_o === 1'b1) begin
			n_conv_o++;
			chk(res_o.data === SMP, "osc data");
		end
		if (cyc == 60000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic t_idle();
		chk(sleep === 1'b0, "mode");
		chk(oe === 1'b0, "oe idle");
	endtask
	task automatic t_convert();
		n_conv = 0;
		n_uns = 0;
		n_conv_o = 0;
		i_aswo_host.hold(1'b0, 1'b0, 300);
		i_aswo_host.pulses(612 * 4);
		#2000;
		chk(oe === 1'b1, "oe on");
		chk(n_conv == 4, "count");
		chk(n_uns == 3, "unsettled");
		chk(n_conv_o == 0, "osc on sclk");
	endtask
	task automatic t_osc();
		n_conv = 0;
		n_conv_o = 0;
		repeat (612) begin
			#400 osc = 1'b1;
			#400 osc = 1'b0;
		end
		#2000;
		chk(n_conv_o == 1, "osc count");
		chk(n_conv == 0, "ext idle");
	endtask
	task automatic t_sleep();
		i_aswo_host.hold(1'b1, 1'b0, (SLP - 6) * 100);
		i_aswo_host.hold(1'b0, 1'b0, 1000);
		chk(sleep === 1'b0, "early");
		i_aswo_host.hold(1'b1, 1'b0, (SLP + 10) * 100);
		chk(sleep === 1'b1, "sleep");
		chk(oe === 1'b1, "oe asleep");
		i_aswo_host.hold(1'b1, 1'b1, 1000);
		chk(oe === 1'b0, "oe off");
		i_aswo_host.hold(1'b0, 1'b1, 5000);
		i_aswo_host.hold(1'b1, 1'b1, 1000);
		chk(sleep === 1'b1, "short low");
		n_rst = 0;
		i_aswo_host.hold(1'b0, 1'b1, 11500);
		chk(sleep === 1'b0, "wake");
		chk(n_rst == 1, "filter");
	endtask
	initial begin
		rst_n = 1'b0;
		osc = 1'b0;
		repeat (10) @(posedge clk);
		#5 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#5;
		t_idle();
		t_convert();
		t_sleep();
		t_convert();
		t_osc();
		close_out();
	end
endmodule
`default_nettype wire
